// ---- hdl/chifb_pkg.sv ----
// constants, state type and helpers for the connect identity and heartbeat framer
// assumes one 50 MHz core clock and a byte stream toward a tcp/udp stack
// ---------------------------------------------------------------------------
// Operation
// - hardware address option: send own hardware address when the connection opens.
// - fixed framing: on connect send fa 07 13 02 fa 02, address, fa ff.
// - address bytes in the fixed sequence go from index five down to zero.
// - fixed framing: every outbound data block is preceded by fa 01 01.
// - fixed framing: one keep-alive byte 00 per keep-alive interval.
// - fixed framing: no transparent pass-through, outbound traffic is always framed.
// - custom identification enabled: send configured bytes exactly on each connect.
// - custom identification string holds at most 33 bytes.
// - custom identification and keep-alive also work over udp transport.
// - keep-alive transmissions are spaced by the interval set in seconds.
// - tcp client: failed keep-alive leads to automatic reconnection.
// - tcp client: implied keep-alive probe each interval without configured content.
// - implied keep-alive carries no payload bytes to the server.
// - custom keep-alive bytes are the second parameter entry, after the identification.
// - identification plus keep-alive content stays below 33 bytes.
// ---------------------------------------------------------------------------

package chifb_pkg;
   // ---------------------------------------------------------------------------
   // framing bytes
   // ---------------------------------------------------------------------------
   localparam logic [47:0] FIX_ID_HEAD  = 48'hfa07_1302_fa02;
   localparam logic [15:0] FIX_ID_TAIL  = 16'hfaff;
   localparam logic [23:0] DATA_HDR     = 24'hfa_0101;
   localparam logic [7:0]  KA_BYTE      = 8'h00;
   localparam logic [5:0]  FIX_ID_LEN   = 6'h0e;
   localparam logic [5:0]  HEAD_LEN     = 6'h06;
   localparam logic [5:0]  MAC_LEN      = 6'h06;
   localparam logic [5:0]  HDR_LEN      = 6'h03;
   localparam logic [5:0]  KA_FIX_LEN   = 6'h01;
   // ---------------------------------------------------------------------------
   // parameter store sizes
   // ---------------------------------------------------------------------------
   localparam int          PARAM_DEPTH  = 33;
   localparam logic [5:0]  ID_MAX       = 6'h21;
   localparam logic [5:0]  COMBINED_MAX = 6'h20;
   // ---------------------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------------------
   localparam int          SEC_NS         = 1000000000;
   localparam int          CLK_NS         = 20;
   localparam int          CYCLES_PER_SEC = SEC_NS / CLK_NS;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ID,
      ST_HDR,
      ST_DATA,
      ST_KA
   } chifb_state_t;

   // byte of the fixed identification sequence, address most significant first
   function automatic logic [7:0] fix_id_byte(input logic [5:0] idx, input logic [47:0] mac);
      logic [5:0] m;
      m = idx - HEAD_LEN;
      if (idx < HEAD_LEN)
         fix_id_byte = FIX_ID_HEAD[6'd47 - {idx[2:0], 3'b000} -: 8];
      else if (idx < HEAD_LEN + MAC_LEN)
         fix_id_byte = mac[{3'd5 - m[2:0], 3'b000} +: 8];
      else
         fix_id_byte = (idx == FIX_ID_LEN - 6'd2) ? FIX_ID_TAIL[15:8] : FIX_ID_TAIL[7:0];
   endfunction
endpackage

// ---- hdl/chifb_ka_if.sv ----
// keep-alive timer control bundle between the framer and its interval timer
// assumes both ends run on the same core clock
`timescale 1ns/100ps

interface chifb_ka_if;
   logic        run;
   logic        restart;
   logic [15:0] interval_s;
   logic        due;

   modport timer (input run, input restart, input interval_s, output due);
   modport ctrl  (output run, output restart, output interval_s, input due);
endinterface

// ---- hdl/chifb_ka_timer.sv ----
// keep-alive interval timer counting whole seconds of the core clock
// assumes restart is a one-cycle pulse and run drops when the link closes
`timescale 1ns/100ps

module chifb_ka_timer #(
   parameter int CYCLES_PER_SEC = chifb_pkg::CYCLES_PER_SEC
) (
   // clock and reset
   input  wire logic     clk,
   input  wire logic     rst_n,
   // control bundle
   chifb_ka_if.timer     ka
);
   logic [31:0] pre_r;
   logic [15:0] sec_r;
   logic        due_r;

   assign ka.due = due_r;

   // ---------------------------------------------------------------------------
   // second prescaler and second counter
   // ---------------------------------------------------------------------------
   // timer start and stop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 32'h0000_0000;
         sec_r <= 16'h0000;
      end else if (!ka.run || ka.restart) begin
         pre_r <= 32'h0000_0000;
         sec_r <= 16'h0000;
      end else if (pre_r == 32'(CYCLES_PER_SEC - 1)) begin
         pre_r <= 32'h0000_0000;
         sec_r <= (sec_r == 16'hffff) ? sec_r : sec_r + 16'h0001;
      end else begin
         pre_r <= pre_r + 32'h0000_0001;
      end
   end

   // due once the interval elapsed
   // due holds until restart so a busy framer does not lose the heartbeat
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         due_r <= 1'b0;
      else if (!ka.run || ka.restart)
         due_r <= 1'b0;
      else if (ka.interval_s != 16'h0000 && sec_r >= ka.interval_s)
         due_r <= 1'b1;
   end
endmodule

// ---- hdl/chifb_framer.sv ----
// connect identity and heartbeat framer, top level
// assumes the stack reports link state as a level and gives byte-wise back-pressure
`timescale 1ns/100ps

module chifb_framer #(
   parameter int CYCLES_PER_SEC = chifb_pkg::CYCLES_PER_SEC
) (
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   // configuration
   input  wire logic        FIXED_FRAMING_PROTOCOL,
   input  wire logic        HARDWARE_ADDRESS_ON_CONNECT,
   input  wire logic        CUSTOM_ID_EN,
   input  wire logic        TCP_CLIENT,
   input  wire logic [47:0] HW_ADDR,
   input  wire logic [15:0] KA_INTERVAL_S,
   input  wire logic [5:0]  ID_LEN,
   input  wire logic [5:0]  KA_LEN,
   // parameter entry store write
   input  wire logic        PARAM_WR,
   input  wire logic [5:0]  PARAM_ADDR,
   input  wire logic [7:0]  PARAM_DATA,
   // connection state from the stack, reconnect and probe requests to it
   input  wire logic        CONN_UP,
   input  wire logic        KA_FAIL,
   output logic             RECONNECT,
   output logic             KA_PROBE,
   // serial side stream in
   input  wire logic [7:0]  SER_DATA,
   input  wire logic        SER_VALID,
   input  wire logic        SER_LAST,
   output logic             SER_READY,
   // network side stream out
   output logic [7:0]       TX_DATA,
   output logic             TX_VALID,
   output logic             TX_LAST,
   input  wire logic        TX_READY
);
   chifb_ka_if              ka_bus();
   chifb_pkg::chifb_state_t state_r;
   logic [7:0]              mem_r [chifb_pkg::PARAM_DEPTH];
   logic [5:0]              idx_r;
   logic [5:0]              id_len;
   logic [5:0]              ka_len;
   logic [5:0]              seq_len;
   logic [7:0]              seq_byte;
   logic [5:0]              ka_addr;
   logic                    conn_d_r;
   logic                    id_done_r;
   logic                    slot;
   logic                    seq_end;
   logic                    ka_has_bytes;
   logic [7:0]              tx_data_r;
   logic                    tx_valid_r;
   logic                    tx_last_r;
   logic                    probe_r;
   logic                    recon_r;

   // ---------------------------------------------------------------------------
   // interval timer
   // ---------------------------------------------------------------------------
   chifb_ka_timer #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_timer (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .ka    (ka_bus.timer)
   );

   assign ka_bus.run        = CONN_UP;
   assign ka_bus.interval_s = KA_INTERVAL_S;
   assign ka_bus.restart    = (state_r == chifb_pkg::ST_KA && seq_end) || probe_r;

   // ---------------------------------------------------------------------------
   // parameter store: identification entry first, keep-alive entry after it
   // ---------------------------------------------------------------------------
   // identification clipped to 33
   assign id_len = (ID_LEN > chifb_pkg::ID_MAX) ? chifb_pkg::ID_MAX : ID_LEN;
   assign ka_len = (id_len >= chifb_pkg::COMBINED_MAX) ? 6'h00 :
                   (KA_LEN > chifb_pkg::COMBINED_MAX - id_len) ? chifb_pkg::COMBINED_MAX - id_len : KA_LEN;
   // keep-alive bytes follow the first entry
   assign ka_addr = id_len + idx_r;

   // writes beyond the store are dropped silently
   always_ff @(posedge CORE_CLK) begin
      if (PARAM_WR && PARAM_ADDR < chifb_pkg::ID_MAX)
         mem_r[PARAM_ADDR] <= PARAM_DATA;
   end

   // ---------------------------------------------------------------------------
   // byte source and length of the sequence in progress
   // ---------------------------------------------------------------------------
   // fixed framing sends its own heartbeat even with no custom content
   assign ka_has_bytes = FIXED_FRAMING_PROTOCOL || ka_len != 6'h00;

   always_comb begin
      seq_len  = 6'h01;
      seq_byte = 8'h00;
      case (state_r)
         chifb_pkg::ST_ID: begin
            if (FIXED_FRAMING_PROTOCOL) begin
               seq_len  = chifb_pkg::FIX_ID_LEN;
               seq_byte = chifb_pkg::fix_id_byte(idx_r, HW_ADDR);
            end else if (HARDWARE_ADDRESS_ON_CONNECT) begin
               seq_len  = chifb_pkg::MAC_LEN;
               seq_byte = HW_ADDR[{3'd5 - idx_r[2:0], 3'b000} +: 8];
            end else begin
               seq_len  = id_len;
               seq_byte = mem_r[idx_r];
            end
         end
         chifb_pkg::ST_HDR: begin
            seq_len  = chifb_pkg::HDR_LEN;
            seq_byte = chifb_pkg::DATA_HDR[6'd23 - {idx_r[2:0], 3'b000} -: 8];
         end
         chifb_pkg::ST_KA: begin
            if (FIXED_FRAMING_PROTOCOL) begin
               seq_len  = chifb_pkg::KA_FIX_LEN;
               seq_byte = chifb_pkg::KA_BYTE;
            end else begin
               seq_len  = ka_len;
               seq_byte = mem_r[ka_addr];
            end
         end
         default: begin
            seq_len  = 6'h01;
            seq_byte = 8'h00;
         end
      endcase
   end

   // a byte may be loaded when the output register is free or being drained
   assign slot    = !tx_valid_r || TX_READY;
   assign seq_end = slot && (idx_r == seq_len - 6'h01);

   // serial bytes only pass in ST_DATA, inside a framed or transparent block
   assign SER_READY = (state_r == chifb_pkg::ST_DATA) && slot && CONN_UP;

   // ---------------------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r   <= chifb_pkg::ST_IDLE;
         idx_r     <= 6'h00;
         id_done_r <= 1'b0;
         conn_d_r  <= 1'b0;
      end else begin
         conn_d_r <= CONN_UP;
         if (!CONN_UP) begin
            state_r   <= chifb_pkg::ST_IDLE;
            idx_r     <= 6'h00;
            id_done_r <= 1'b0;
         end else begin
            case (state_r)
               chifb_pkg::ST_IDLE: begin
                  idx_r <= 6'h00;
                  if (!id_done_r) begin
                     id_done_r <= 1'b1;
                     if (FIXED_FRAMING_PROTOCOL || HARDWARE_ADDRESS_ON_CONNECT ||
                         (CUSTOM_ID_EN && id_len != 6'h00))
                        state_r <= chifb_pkg::ST_ID;
                  end else if (ka_bus.due && ka_has_bytes)
                     state_r <= chifb_pkg::ST_KA;
                  else if (SER_VALID)
                     state_r <= FIXED_FRAMING_PROTOCOL ? chifb_pkg::ST_HDR : chifb_pkg::ST_DATA;
               end
               chifb_pkg::ST_ID, chifb_pkg::ST_KA: begin
                  if (seq_end) begin
                     state_r <= chifb_pkg::ST_IDLE;
                     idx_r   <= 6'h00;
                  end else if (slot)
                     idx_r <= idx_r + 6'h01;
               end
               chifb_pkg::ST_HDR: begin
                  if (seq_end) begin
                     state_r <= chifb_pkg::ST_DATA;
                     idx_r   <= 6'h00;
                  end else if (slot)
                     idx_r <= idx_r + 6'h01;
               end
               chifb_pkg::ST_DATA: begin
                  if (SER_READY && SER_VALID && SER_LAST)
                     state_r <= chifb_pkg::ST_IDLE;
               end
               default: begin
                  state_r <= chifb_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------------------
   // output byte register
   // ---------------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_data_r  <= 8'h00;
         tx_valid_r <= 1'b0;
         tx_last_r  <= 1'b0;
      end else if (!CONN_UP) begin
         tx_valid_r <= 1'b0;
         tx_last_r  <= 1'b0;
      end else if (slot) begin
         if (state_r == chifb_pkg::ST_DATA) begin
            tx_data_r  <= SER_DATA;
            tx_valid_r <= SER_VALID;
            tx_last_r  <= SER_LAST;
         end else if (state_r == chifb_pkg::ST_ID || state_r == chifb_pkg::ST_KA ||
                      state_r == chifb_pkg::ST_HDR) begin
            tx_data_r  <= seq_byte;
            tx_valid_r <= 1'b1;
            tx_last_r  <= seq_end && state_r != chifb_pkg::ST_HDR;
         end else begin
            tx_valid_r <= 1'b0;
            tx_last_r  <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // implied heartbeat and reconnection
   // ---------------------------------------------------------------------------
   // tcp client probe without content
   // probe is a pulse to the stack, never a byte on the stream
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN)
         probe_r <= 1'b0;
      else
         probe_r <= CONN_UP && TCP_CLIENT && !ka_has_bytes && ka_bus.due &&
                    state_r == chifb_pkg::ST_IDLE && id_done_r && !probe_r;
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN)
         recon_r <= 1'b0;
      else
         recon_r <= TCP_CLIENT && KA_FAIL;
   end

   assign TX_DATA   = tx_data_r;
   assign TX_VALID  = tx_valid_r;
   assign TX_LAST   = tx_last_r;
   assign KA_PROBE  = probe_r;
   assign RECONNECT = recon_r;

   // ---------------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------------
   sequence s_connect;
      CONN_UP && !conn_d_r;
   endsequence
   sequence s_byte_taken;
      tx_valid_r && TX_READY;
   endsequence

   id_first_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      s_connect |=> (state_r != chifb_pkg::ST_DATA && state_r != chifb_pkg::ST_HDR))
      else $error("data started before identification");
   fix_head_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (state_r == chifb_pkg::ST_ID && FIXED_FRAMING_PROTOCOL && idx_r == 6'h00 && slot)
      |=> tx_data_r == 8'hfa)
      else $error("fixed identification does not open with fa");
   mac_order_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (state_r == chifb_pkg::ST_ID && FIXED_FRAMING_PROTOCOL && idx_r == 6'h06 && slot)
      |=> tx_data_r == $past(HW_ADDR[47:40]))
      else $error("address byte five not first");
   hdr_first_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (FIXED_FRAMING_PROTOCOL && $rose(state_r == chifb_pkg::ST_DATA)) |-> $past(state_r) == chifb_pkg::ST_HDR)
      else $error("framed data without header");
   ka_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (state_r == chifb_pkg::ST_KA && FIXED_FRAMING_PROTOCOL && slot && CONN_UP) |=> tx_data_r == 8'h00 && tx_last_r)
      else $error("fixed heartbeat is not a single zero");
   probe_empty_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      KA_PROBE |-> state_r != chifb_pkg::ST_KA ##1 !KA_PROBE)
      else $error("probe not a lone pulse");
   recon_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (TCP_CLIENT && KA_FAIL) |=> RECONNECT)
      else $error("no reconnect after failed heartbeat");
   // a lone identification may use all 33 bytes; the limit binds once heartbeat content exists
   combined_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      ka_len == 6'h00 || (7'(id_len) + 7'(ka_len)) < 7'h21)
      else $error("combined entry length too long");
   stop_down_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      !CONN_UP |=> !ka_bus.due && !TX_VALID)
      else $error("activity while disconnected");
   // in fixed framing a serial byte is only taken inside a block that a header opened
   hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (FIXED_FRAMING_PROTOCOL && SER_READY) |->
         ($past(state_r) == chifb_pkg::ST_HDR || $past(state_r) == chifb_pkg::ST_DATA))
      else $error("serial byte passed without framing");
   // a byte on the stream stays put until the server takes it
   tx_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      (CONN_UP && tx_valid_r && !TX_READY) |=> (!CONN_UP || (tx_valid_r && $stable(tx_data_r))))
      else $error("output byte dropped");
endmodule

// ---- verification/chifb_server_model.sv ----
// server side model: takes the framed byte stream and logs each byte with its cycle
// assumes the framer's network stream runs on the same core clock
`timescale 1ns/100ps

module chifb_server_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // stall control from the bench
   input  wire logic       slow,
   // framed stream from the device
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       tx_last,
   output logic            tx_ready
);
   logic [7:0] rx_q[$];
   int         rx_t[$];
   int         cyc = 0;
   int         hb_cnt = 0;
   logic       pkt_start_r = 1'b1;

   // ready pattern: prompt or random stalls, always changed just after the edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
      end
   end

   // log every byte for the bench; the log is the wire view, not the application view
   // heartbeat not data
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready) begin
         rx_q.push_back(tx_data);
         rx_t.push_back(cyc);
         pkt_start_r <= tx_last;
         if (pkt_start_r && tx_last && tx_data == 8'h00) begin
            hb_cnt <= hb_cnt + 1;
         end
      end
   end
endmodule

// ---- verification/chifb_framer_test.sv ----
// self-checking bench for the connect identity and heartbeat framer
// assumes the server model is compiled first; one second is scaled to CPS cycles
`timescale 1ns/100ps

module chifb_framer_test;
   localparam int CPS = 200;
   logic        core_clk = 0, resetn = 0, fixed = 0, hwa = 0, cid_en = 0, tcp = 0, slow = 0;
   logic [47:0] hw_addr = 48'h0;
   logic [15:0] ka_s = 16'h0;
   logic [5:0]  id_len = 6'h0, ka_len = 6'h0, param_addr = 6'h0;
   logic [7:0]  param_data = 8'h0, ser_data = 8'h0, tx_data;
   logic        param_wr = 0, conn_up = 0, ka_fail = 0, ser_valid = 0, ser_last = 0;
   logic        reconnect, ka_probe, ser_ready, tx_valid, tx_last, tx_ready;
   logic [7:0]  store [0:32];
   logic [7:0]  exp_q[$];
   int          err_total = 0, compares = 0, cyc = 0;

   chifb_framer #(.CYCLES_PER_SEC(CPS)) chifb_framer_i (
      .CORE_CLK(core_clk), .RESETN(resetn), .FIXED_FRAMING_PROTOCOL(fixed),
      .HARDWARE_ADDRESS_ON_CONNECT(hwa), .CUSTOM_ID_EN(cid_en), .TCP_CLIENT(tcp),
      .HW_ADDR(hw_addr), .KA_INTERVAL_S(ka_s), .ID_LEN(id_len), .KA_LEN(ka_len),
      .PARAM_WR(param_wr), .PARAM_ADDR(param_addr), .PARAM_DATA(param_data),
      .CONN_UP(conn_up), .KA_FAIL(ka_fail), .RECONNECT(reconnect), .KA_PROBE(ka_probe),
      .SER_DATA(ser_data), .SER_VALID(ser_valid), .SER_LAST(ser_last), .SER_READY(ser_ready),
      .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready));

   chifb_server_model server_i (
      .clk(core_clk), .rst_n(resetn), .slow(slow), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

   // 50 mhz core clock
   initial begin
      forever #10 core_clk = ~core_clk;
   end

   // hang guard: ceiling well above the roughly 1300 cycles the run needs
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end

   task automatic test_done();
      if (err_total == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // compare the logged bytes against exp_q; gap is the spacing of the last two bytes
   task automatic expect_rx(output int gap);
      for (int w = 0; w < 600 && server_i.rx_q.size() < exp_q.size(); w++) begin
         @(posedge core_clk);
      end
      chk(48'(server_i.rx_q.size()), 48'(exp_q.size()));
      foreach (exp_q[i]) chk(server_i.rx_q[i], exp_q[i]);
      gap = (server_i.rx_t.size() > 1) ? server_i.rx_t[$] - server_i.rx_t[$ - 1] : 0;
      server_i.rx_q.delete();
      server_i.rx_t.delete();
      exp_q.delete();
   endtask

   // close the link; the caller changes the setup and raises it again
   task automatic drop();
      @(posedge core_clk);
      conn_up <= 1'b0;
      repeat (3) @(posedge core_clk);
      server_i.rx_q.delete();
      server_i.rx_t.delete();
   endtask

   // one serial block of random length, expected bytes queued behind an optional header
   task automatic send_blk(input bit hdr);
      int         n;
      logic [7:0] b;
      n = 1 + $urandom % 8;
      if (hdr) exp_q = '{8'hfa, 8'h01, 8'h01};
      @(posedge core_clk);
      for (int i = 0; i < n; i++) begin
         b = 8'($urandom);
         exp_q.push_back(b);
         ser_data <= b;
         ser_valid <= 1'b1;
         ser_last <= (i == n - 1);
         for (int w = 0; w < 200; w++) begin
            @(negedge core_clk);
            if (ser_ready === 1'b1) break;
         end
         @(posedge core_clk);
      end
      ser_valid <= 1'b0;
      ser_last <= 1'b0;
   endtask

   task automatic push_addr(input logic [47:0] a);
      for (int i = 5; i >= 0; i--) exp_q.push_back(a[i*8 +: 8]);
   endtask

   task automatic push_store(input int from, input int cnt);
      for (int i = from; i < from + cnt; i++) exp_q.push_back(store[i]);
   endtask

   task automatic count_probe(output int c);
      c = 0;
      repeat (CPS + 10) begin
         @(negedge core_clk);
         c += (ka_probe === 1'b1);
      end
   endtask

   // main sequence
   initial begin
      logic [47:0] a;
      int          g, n;
      void'($urandom(32'hdb2e));
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 33; i++) begin
         store[i] = 8'($urandom);
         @(posedge core_clk);
         param_wr <= 1'b1;
         param_addr <= 6'(i);
         param_data <= store[i];
      end
      @(posedge core_clk);
      param_wr <= 1'b0;
      // fixed framing: identification and block under random stalls, heartbeats without
      a = {16'($urandom), $urandom};
      hw_addr <= a;
      fixed <= 1'b1;
      cid_en <= 1'b0;
      ka_s <= 16'h1;
      slow <= 1'b1;
      conn_up <= 1'b1;
      exp_q = '{8'hfa, 8'h07, 8'h13, 8'h02, 8'hfa, 8'h02};
      push_addr(a);
      exp_q.push_back(8'hfa);
      exp_q.push_back(8'hff);
      expect_rx(g);
      send_blk(1'b1);
      expect_rx(g);
      slow <= 1'b0;
      exp_q = '{8'h00, 8'h00};
      expect_rx(g);
      chk(48'(g >= CPS && g <= CPS + 4), 48'h1);
      // hardware address, then a transparent block
      drop();
      chk(48'(server_i.hb_cnt), 48'h2);
      fixed <= 1'b0;
      hwa <= 1'b1;
      ka_s <= 16'h0;
      conn_up <= 1'b1;
      push_addr(a);
      expect_rx(g);
      send_blk(1'b0);
      expect_rx(g);
      // custom id at its longest
      drop();
      hwa <= 1'b0;
      cid_en <= 1'b1;
      id_len <= 6'h21;
      ka_len <= 6'h00;
      slow <= 1'b1;
      conn_up <= 1'b1;
      push_store(0, 33);
      expect_rx(g);
      // custom id plus custom heartbeat over datagram transport
      n = 1 + $urandom % 16;
      drop();
      id_len <= 6'(n);
      ka_len <= 6'(32 - n);
      ka_s <= 16'h1;
      conn_up <= 1'b1;
      push_store(0, n);
      push_store(n, 32 - n);
      expect_rx(g);
      // tcp client with no heartbeat content: implied probe, then failure
      drop();
      cid_en <= 1'b0;
      ka_len <= 6'h00;
      tcp <= 1'b1;
      slow <= 1'b0;
      conn_up <= 1'b1;
      count_probe(g);
      chk(48'(g), 48'h1);
      chk(48'(server_i.rx_q.size()), 48'h0);
      @(posedge core_clk);
      ka_fail <= 1'b1;
      @(posedge core_clk);
      ka_fail <= 1'b0;
      @(negedge core_clk);
      chk(48'(reconnect), 48'h1);
      @(negedge core_clk);
      chk(48'(reconnect), 48'h0);
      drop();
      count_probe(g);
      chk(48'(g), 48'h0);
      test_done();
   end
endmodule
